// >>> design/rtm_pkg.sv
// Package with register map, field layout and timing constants for timers
package rtm_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_RUN_CONTROL  = 8'h0E;
  localparam logic [7:0] ADDR_T0_CONFIG    = 8'h0F;
  localparam logic [7:0] ADDR_T0_RELOAD_HI = 8'h10;
  localparam logic [7:0] ADDR_T0_RELOAD_LO = 8'h11;
  localparam logic [7:0] ADDR_T0_COUNT_HI  = 8'h12;
  localparam logic [7:0] ADDR_T0_COUNT_LO  = 8'h13;
  localparam logic [7:0] ADDR_T1_CONFIG    = 8'h14;

  // Config and run control field positions, and timer counts
  localparam int CFG_HALT_RX_BIT = 7;
  localparam int CFG_MODE_HI     = 5;
  localparam int CFG_MODE_LO     = 4;
  localparam int CFG_RELOAD_BIT  = 3;
  localparam int CFG_CLK_HI      = 1;
  localparam int CFG_CLK_LO      = 0;
  localparam int RUN_STATUS_LO   = 4;
  localparam int NUM_TIMERS      = 4;
  localparam int NUM_FULL        = 2;

  // Writable config bits, reserved bits 6 and 2 read zero
  localparam logic [7:0] CFG_WRITE_MASK = 8'hBB;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam logic [15:0] COUNT_ONE     = 16'h0001;

  // Bits received before a halt-on-receive stop
  localparam logic [2:0] HALT_RX_BITS = 3'h4;

  // Carrier divided by 64 gives the slow tick
  localparam int CARRIER_KHZ = 13560;
  localparam int SLOW_KHZ    = 211875 / 1000;
  localparam int SLOW_DIV    = 64;
  localparam logic [5:0] SLOW_DIV_LAST = 6'(SLOW_DIV - 1);

  typedef enum logic [1:0] {
    MODE_MANUAL   = 2'h0,
    MODE_AUTO_TX  = 2'h1,
    MODE_TRIM     = 2'h2,
    MODE_TRIM_UFL = 2'h3
  } rtm_mode_type;

  typedef enum logic [1:0] {
    CLK_CARRIER = 2'h0,
    CLK_SLOW    = 2'h1,
    CLK_CASC_A  = 2'h2,
    CLK_CASC_B  = 2'h3
  } rtm_clk_type;
endpackage

// >>> design/rtm_counter.sv
// One 16-bit down counter with start, stop, reload and underflow
`timescale 1ns/1ps
module rtm_counter
  import rtm_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Control
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic        tick,
  input  wire logic        auto_reload,
  input  wire logic        trim_no_ufl,
  input  wire logic [15:0] reload_word,
  // Status
  output logic             active,
  output logic [15:0]      count,
  output logic             underflow
);
  logic        active_q, active_d;
  logic [15:0] count_q, count_d;
  logic        ufl_q, ufl_d;

  always_comb begin
    active_d = active_q;
    count_d  = count_q;
    ufl_d    = 1'b0;
    if (start) begin
      count_d  = reload_word;
      active_d = 1'b1;
    end else if (stop) begin
      active_d = 1'b0;
    end else if (active_q && tick) begin
      if (count_q == RESET_WORD) begin
        // Trimming without underflow simply holds at zero
        if (!trim_no_ufl) begin
          ufl_d = 1'b1;
          if (auto_reload) begin
            count_d = reload_word;
          end else begin
            active_d = 1'b0;
          end
        end
      end else begin
        count_d = count_q - COUNT_ONE;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
      count_q  <= RESET_WORD;
      ufl_q    <= 1'b0;
    end else begin
      active_q <= active_d;
      count_q  <= count_d;
      ufl_q    <= ufl_d;
    end
  end

  assign active    = active_q;
  assign count     = count_q;
  assign underflow = ufl_q;
endmodule

// >>> design/rtm_timer_section.sv
// Timer section: run control, timer 0 and timer 1 with register access
`timescale 1ns/1ps
module rtm_timer_section
  import rtm_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Register port
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Radio events from the framing logic, and the slow oscillator pin
  input  wire logic       tx_done,
  input  wire logic       rx_bit,
  input  wire logic       rx_active,
  input  wire logic       slow_osc_pin,
  // Timers 2 and 3 live elsewhere
  input  wire logic       timer2_underflow,
  input  wire logic       timer3_active,
  output logic            timer3_run_write_enable,
  output logic            timer3_run_value,
  output logic            timer2_run_write_enable,
  output logic            timer2_run_value,
  // Status
  output logic            timer2_active_seen,
  output logic [1:0]      timer_underflow_flag
);

  // Config decode used for both full timers
  function automatic logic cfg_halt(input logic [7:0] cfg);
    logic m;
    m = cfg[CFG_MODE_HI];
    cfg_halt = cfg[CFG_HALT_RX_BIT] && !m;
  endfunction

  // Register state
  logic [7:0] cfg_q [NUM_FULL];
  logic [7:0] cfg_d [NUM_FULL];
  logic [7:0] rel_hi_q, rel_hi_d, rel_lo_q, rel_lo_d;
  logic [1:0] flag_q, flag_d;
  logic [2:0] rx_cnt_q, rx_cnt_d;
  logic [5:0] div_q, div_d;
  logic       slow_tick_q, slow_tick_d;
  logic       osc_s1_q, osc_s2_q, osc_prev_q;
  logic       rx_s1_q, rx_s2_q, rxa_s1_q, rxa_s2_q, tx_s1_q, tx_s2_q;
  logic       tx_prev_q, bit_prev_q;
  logic       t2a_s1_q, t2a_s2_q;
  logic [7:0] rdata_q, rdata_d;

  logic [NUM_FULL-1:0] active, start, stop, tick, ufl;
  logic [15:0]         count [NUM_FULL];
  logic                run_wr, halt_hit, tx_end, osc_rise, rx_edge;

  assign run_wr   = reg_write && (reg_addr == ADDR_RUN_CONTROL);
  assign tx_end   = tx_s2_q && !tx_prev_q;
  assign osc_rise = osc_s2_q && !osc_prev_q;
  assign rx_edge  = rx_s2_q && !bit_prev_q;
  assign halt_hit = rxa_s2_q && rx_edge && (rx_cnt_q == HALT_RX_BITS - 3'h1);

  // Per-timer start, stop and tick selection
  generate
    for (genvar i = 0; i < NUM_FULL; i++) begin : g_tmr
      logic [1:0] mode;
      logic [1:0] csel;
      logic       casc_a, casc_b, trim;
      assign mode = cfg_q[i][CFG_MODE_HI:CFG_MODE_LO];
      assign csel = cfg_q[i][CFG_CLK_HI:CFG_CLK_LO];
      assign trim = mode[1];
      // Timer 0: 10 timer 2, 11 timer 1; timer 1: 10 timer 0, 11 timer 2
      assign casc_a = (i == 0) ? timer2_underflow : ufl[0];
      assign casc_b = (i == 0) ? ufl[1] : timer2_underflow;
      always_comb begin
        start[i] = 1'b0;
        stop[i]  = 1'b0;
        if (run_wr && reg_wdata[i]) begin
          start[i] = reg_wdata[RUN_STATUS_LO + i];
          stop[i]  = !reg_wdata[RUN_STATUS_LO + i];
        end else if (mode == MODE_AUTO_TX && tx_end) begin
          start[i] = 1'b1;
        end else if (trim && osc_rise) begin
          // Each rising edge toggles the trim measurement
          start[i] = !active[i];
          stop[i]  = active[i];
        end else if (cfg_halt(cfg_q[i]) && halt_hit) begin
          stop[i] = 1'b1;
        end
        case (csel)
          CLK_CARRIER: tick[i] = 1'b1;
          CLK_SLOW:    tick[i] = slow_tick_q;
          CLK_CASC_A:  tick[i] = casc_a;
          CLK_CASC_B:  tick[i] = casc_b;
          default:     tick[i] = 1'b0;
        endcase
      end
      rtm_counter u_cnt (
        .clock       (clock),
        .rst         (rst),
        .start       (start[i]),
        .stop        (stop[i]),
        .tick        (tick[i]),
        .auto_reload (cfg_q[i][CFG_RELOAD_BIT]),
        .trim_no_ufl (mode == MODE_TRIM),
        .reload_word ({rel_hi_q, rel_lo_q}),
        .active      (active[i]),
        .count       (count[i]),
        .underflow   (ufl[i])
      );
    end
  endgenerate

  // Timer 1 reload registers are not in this section; it shares timer 0's
  always_comb begin
    cfg_d[0] = cfg_q[0];
    cfg_d[1] = cfg_q[1];
    rel_hi_d = rel_hi_q;
    rel_lo_d = rel_lo_q;
    if (reg_write) begin
      case (reg_addr)
        ADDR_T0_CONFIG:    cfg_d[0] = reg_wdata & CFG_WRITE_MASK;
        ADDR_T1_CONFIG:    cfg_d[1] = reg_wdata & CFG_WRITE_MASK;
        ADDR_T0_RELOAD_HI: rel_hi_d = reg_wdata;
        ADDR_T0_RELOAD_LO: rel_lo_d = reg_wdata;
        default:           rel_lo_d = rel_lo_q;
      endcase
    end
    flag_d = flag_q | ufl;
    // Count received bits only while a frame is in progress
    rx_cnt_d = rxa_s2_q ? rx_cnt_q : 3'h0;
    if (rxa_s2_q && rx_edge && rx_cnt_q != HALT_RX_BITS) begin
      rx_cnt_d = rx_cnt_q + 3'h1;
    end
    slow_tick_d = (div_q == SLOW_DIV_LAST);
    div_d       = div_q + 6'h01;
    rdata_d = rdata_q;
    if (reg_read) begin
      case (reg_addr)
        ADDR_RUN_CONTROL:  rdata_d = {timer3_active, t2a_s2_q, active, 4'h0};
        ADDR_T0_CONFIG:    rdata_d = cfg_q[0];
        ADDR_T0_RELOAD_HI: rdata_d = rel_hi_q;
        ADDR_T0_RELOAD_LO: rdata_d = rel_lo_q;
        ADDR_T0_COUNT_HI:  rdata_d = count[0][15:8];
        ADDR_T0_COUNT_LO:  rdata_d = count[0][7:0];
        ADDR_T1_CONFIG:    rdata_d = cfg_q[1];
        default:           rdata_d = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_q[0]    <= RESET_BYTE;
      cfg_q[1]    <= RESET_BYTE;
      rel_hi_q    <= RESET_BYTE;
      rel_lo_q    <= RESET_BYTE;
      flag_q      <= 2'h0;
      rx_cnt_q    <= 3'h0;
      div_q       <= 6'h00;
      slow_tick_q <= 1'b0;
      osc_s1_q    <= 1'b0;
      osc_s2_q    <= 1'b0;
      osc_prev_q  <= 1'b0;
      rx_s1_q     <= 1'b0;
      rx_s2_q     <= 1'b0;
      rxa_s1_q    <= 1'b0;
      rxa_s2_q    <= 1'b0;
      tx_s1_q     <= 1'b0;
      tx_s2_q     <= 1'b0;
      tx_prev_q   <= 1'b0;
      bit_prev_q  <= 1'b0;
      t2a_s1_q    <= 1'b0;
      t2a_s2_q    <= 1'b0;
      rdata_q     <= RESET_BYTE;
    end else begin
      cfg_q[0]    <= cfg_d[0];
      cfg_q[1]    <= cfg_d[1];
      rel_hi_q    <= rel_hi_d;
      rel_lo_q    <= rel_lo_d;
      flag_q      <= flag_d;
      rx_cnt_q    <= rx_cnt_d;
      div_q       <= div_d;
      slow_tick_q <= slow_tick_d;
      osc_s1_q    <= slow_osc_pin;
      osc_s2_q    <= osc_s1_q;
      osc_prev_q  <= osc_s2_q;
      rx_s1_q     <= rx_bit;
      rx_s2_q     <= rx_s1_q;
      rxa_s1_q    <= rx_active;
      rxa_s2_q    <= rxa_s1_q;
      tx_s1_q     <= tx_done;
      tx_s2_q     <= tx_s1_q;
      tx_prev_q   <= tx_s2_q;
      bit_prev_q  <= rx_s2_q;
      t2a_s1_q    <= timer2_underflow;
      t2a_s2_q    <= t2a_s1_q;
      rdata_q     <= rdata_d;
    end
  end

  // Timers 2 and 3 take their run bit from the same masked write
  assign timer2_run_write_enable = run_wr && reg_wdata[2];
  assign timer2_run_value        = reg_wdata[6];
  assign timer3_run_write_enable = run_wr && reg_wdata[3];
  assign timer3_run_value        = reg_wdata[7];
  assign timer2_active_seen      = t2a_s2_q;
  assign timer_underflow_flag    = flag_q;
  assign reg_rdata               = rdata_q;
endmodule

// >>> sim/rtm_timer_section_checker.sv
// Port-level assertions for the timer section
`timescale 1ns/1ps
module rtm_timer_section_checker
  import rtm_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // Register port
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Status
  input wire logic       timer3_run_write_enable,
  input wire logic       timer3_run_value,
  input wire logic       timer2_run_write_enable,
  input wire logic       timer2_run_value,
  input wire logic [1:0] timer_underflow_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic run_wr;
  logic is_cfg;
  assign run_wr = reg_write && reg_addr == ADDR_RUN_CONTROL;
  assign is_cfg = reg_addr == ADDR_T0_CONFIG || reg_addr == ADDR_T1_CONFIG;

  t3_enable_a: assert property (
    timer3_run_write_enable == (run_wr && reg_wdata[3])) else $error("t3 en");
  t2_enable_a: assert property (
    timer2_run_write_enable == (run_wr && reg_wdata[2])) else $error("t2 en");
  t3_value_a: assert property (
    run_wr && reg_wdata[3] |-> timer3_run_value == reg_wdata[7])
    else $error("t3 value");
  t2_value_a: assert property (
    run_wr && reg_wdata[2] |-> timer2_run_value == reg_wdata[6])
    else $error("t2 value");
  flag0_hold_a: assert property (
    timer_underflow_flag[0] |=> timer_underflow_flag[0]) else $error("flag0");
  flag1_hold_a: assert property (
    timer_underflow_flag[1] |=> timer_underflow_flag[1]) else $error("flag1");
  rdata_hold_a: assert property (
    !reg_read |=> $stable(reg_rdata)) else $error("rdata moved");
  cfg_reserved_a: assert property (
    reg_read && is_cfg |=> (reg_rdata & ~CFG_WRITE_MASK) == 8'h00)
    else $error("reserved bits");
  cfg_readback_a: assert property (
    reg_write && reg_addr == ADDR_T1_CONFIG ##1 reg_read && !reg_write &&
    reg_addr == ADDR_T1_CONFIG |=>
    reg_rdata == ($past(reg_wdata, 2) & CFG_WRITE_MASK))
    else $error("cfg readback");
endmodule

bind rtm_timer_section rtm_timer_section_checker chk_u (.clock, .rst,
  .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
  .timer3_run_write_enable, .timer3_run_value, .timer2_run_write_enable,
  .timer2_run_value, .timer_underflow_flag);

// >>> sim/rtm_timer_section_test.sv
// Self-checking bench for the timer section
`timescale 1ns/1ps
module rtm_timer_section_test
  import rtm_pkg::*;
();
  logic        clock, rst, reg_write, reg_read, tx_done, rx_bit;
  logic        rx_active, slow_osc_pin, timer2_underflow, timer3_active;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
  logic [1:0]  flags;
  int          fails, check_count, cycles;
  // Address, write data, expected read back
  logic [23:0] rows [8] = '{24'h0F_FFBB, 24'h14_FFBB, 24'h14_4400,
    24'h10_A5A5, 24'h11_5A5A, 24'h15_7700, 24'h12_FF00, 24'h0E_F000};
  logic [7:0]  hcfg [3] = '{8'h82, 8'h02, 8'hA2};
  logic [7:0]  hexp [3] = '{8'h00, 8'h10, 8'h10};

  rtm_timer_section dut_u (.clock, .rst, .reg_write, .reg_read,
    .reg_addr, .reg_wdata, .reg_rdata, .tx_done, .rx_bit, .rx_active,
    .slow_osc_pin, .timer2_underflow, .timer3_active,
    .timer3_run_write_enable(), .timer3_run_value(),
    .timer2_run_write_enable(), .timer2_run_value(),
    .timer2_active_seen(), .timer_underflow_flag(flags));

  always #50 clock = ~clock;

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_write = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_write = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    reg_read = 1'h1;
    reg_addr = a;
    cyc(1);
    reg_read = 1'h0;
    rv = reg_rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Cascade ticks only come from here, so counts are exact
  task automatic t2tick;
    timer2_underflow = 1'h1;
    cyc(1);
    timer2_underflow = 1'h0;
    cyc(5);
  endtask

  initial begin
    clock = 1'h0;
    rst = 1'h1;
    {reg_write, reg_read, tx_done, rx_bit, rx_active} = 5'h00;
    {slow_osc_pin, timer2_underflow, timer3_active} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (8) @(posedge clock);
    #1;
    rst = 1'h0;
    for (int a = 14; a <= 20; a++) begin
      rd(8'(a));
      chk("reset", rv, 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk("row", rv, rows[i][7:0]);
    end
    wr(ADDR_T0_CONFIG, 8'h02);
    wr(ADDR_T0_RELOAD_HI, 8'h00);
    wr(ADDR_T0_RELOAD_LO, 8'h02);
    wr(ADDR_RUN_CONTROL, 8'h11);
    rd(ADDR_T0_COUNT_LO);
    chk("load", rv, 8'h02);
    t2tick();
    rd(ADDR_T0_COUNT_LO);
    chk("cascade", rv, 8'h01);
    t2tick();
    // Underflow is the step from zero, so a third tick ends the run
    t2tick();
    rd(ADDR_RUN_CONTROL);
    chk("one shot", rv, 8'h00);
    wr(ADDR_T0_CONFIG, 8'h0A);
    wr(ADDR_T0_RELOAD_LO, 8'h01);
    wr(ADDR_RUN_CONTROL, 8'h11);
    repeat (3) t2tick();
    chk("flag0", {7'h00, flags[0]}, 8'h01);
    rd(ADDR_RUN_CONTROL);
    chk("reload", rv, 8'h10);
    wr(ADDR_T0_RELOAD_LO, 8'h09);
    wr(ADDR_RUN_CONTROL, 8'h01);
    rd(ADDR_RUN_CONTROL);
    chk("stop", rv, 8'h00);
    wr(ADDR_RUN_CONTROL, 8'h11);
    rd(ADDR_T0_COUNT_LO);
    chk("new reload", rv, 8'h09);
    wr(ADDR_RUN_CONTROL, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_T0_CONFIG, hcfg[k]);
      wr(ADDR_RUN_CONTROL, 8'h11);
      rx_active = 1'h1;
      repeat (4) begin
        rx_bit = 1'h1;
        cyc(3);
        rx_bit = 1'h0;
        cyc(3);
      end
      rx_active = 1'h0;
      rd(ADDR_RUN_CONTROL);
      chk("halt rx", rv, hexp[k]);
      wr(ADDR_RUN_CONTROL, 8'h01);
    end
    slow_osc_pin = 1'h1;
    cyc(5);
    rd(ADDR_RUN_CONTROL);
    chk("trim on", rv, 8'h10);
    slow_osc_pin = 1'h0;
    cyc(5);
    slow_osc_pin = 1'h1;
    cyc(5);
    rd(ADDR_RUN_CONTROL);
    chk("trim off", rv, 8'h00);
    wr(ADDR_T0_CONFIG, 8'h12);
    tx_done = 1'h1;
    cyc(4);
    tx_done = 1'h0;
    cyc(4);
    rd(ADDR_RUN_CONTROL);
    chk("auto start", rv, 8'h10);
    wr(ADDR_RUN_CONTROL, 8'h01);
    // At most two slow ticks fit in 100 cycles, at least four in 260
    wr(ADDR_T0_CONFIG, 8'h01);
    wr(ADDR_T0_RELOAD_LO, 8'h03);
    wr(ADDR_RUN_CONTROL, 8'h11);
    cyc(100);
    rd(ADDR_RUN_CONTROL);
    chk("slow run", rv, 8'h10);
    cyc(160);
    rd(ADDR_RUN_CONTROL);
    chk("slow end", rv, 8'h00);
    wr(ADDR_T0_CONFIG, 8'h00);
    wr(ADDR_T0_RELOAD_LO, 8'h10);
    wr(ADDR_RUN_CONTROL, 8'h11);
    cyc(30);
    rd(ADDR_RUN_CONTROL);
    chk("carrier", rv, 8'h00);
    wr(ADDR_T1_CONFIG, 8'h08);
    wr(ADDR_RUN_CONTROL, 8'h22);
    cyc(40);
    chk("flag1", {7'h00, flags[1]}, 8'h01);
    rd(ADDR_RUN_CONTROL);
    chk("t1 run", rv, 8'h20);
    // Timer 1 counts timer 0 underflows, one every three cycles
    wr(ADDR_T1_CONFIG, 8'h02);
    wr(ADDR_T0_CONFIG, 8'h08);
    wr(ADDR_T0_RELOAD_LO, 8'h02);
    wr(ADDR_RUN_CONTROL, 8'h33);
    cyc(20);
    rd(ADDR_RUN_CONTROL);
    chk("t1 cascade", rv, 8'h10);
    wr(ADDR_RUN_CONTROL, 8'h03);
    timer3_active = 1'h1;
    cyc(4);
    rd(ADDR_RUN_CONTROL);
    chk("t3 state", rv, 8'h80);
    conclude();
  end
endmodule
